// [hdl/twi_line_if.sv]
`timescale 1ns/10ps
// Sampled bus line levels and their decoded events
interface twi_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    modport producer (output scl, sda, scl_rise, scl_fall, start_ev, stop_ev);
    modport consumer (input  scl, sda, scl_rise, scl_fall, start_ev, stop_ev);
endinterface

// [hdl/twi_line_sync.sv]
`timescale 1ns/10ps
module twi_line_sync
    import twi_port_pkg::*;
(
    input  wire logic     i_mclk,
    input  wire logic     i_reset_n,
    input  wire logic     i_scl,
    input  wire logic     i_sda,
    twi_line_if.producer  line
);
    typedef struct packed {
        logic [1:0] scl_meta;
        logic [1:0] sda_meta;
        logic       scl_old;
        logic       sda_old;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // --------------------------------------------------------------------
    // Two-stage synchronisers, then edge history
    // --------------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.scl_meta = {s_q.scl_meta[0], i_scl};
        s_d.sda_meta = {s_q.sda_meta[0], i_sda};
        s_d.scl_old  = s_q.scl_meta[1];
        s_d.sda_old  = s_q.sda_meta[1];
    end

    // Idle bus is high, so reset to high avoids a false start
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_old: 1'b1, sda_old: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // Only the second stage and its edge history feed decode
    assign line.scl      = s_q.scl_meta[1];
    assign line.sda      = s_q.sda_meta[1];
    assign line.scl_rise = s_q.scl_meta[1] & ~s_q.scl_old;
    assign line.scl_fall = ~s_q.scl_meta[1] & s_q.scl_old;
    assign line.start_ev = s_q.scl_meta[1] & s_q.scl_old & s_q.sda_old & ~s_q.sda_meta[1];
    assign line.stop_ev  = s_q.scl_meta[1] & s_q.scl_old & ~s_q.sda_old & s_q.sda_meta[1];
endmodule

// [hdl/twi_port_pkg.sv]
package twi_port_pkg;
    // Slave addresses selected by the strap pin
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1D;
    localparam logic [6:0] ADDR_STRAP_LOW  = 7'h53;
    // Bus rates the port is designed for, in kHz
    localparam int unsigned RATE_STD_KHZ  = 100;
    localparam int unsigned RATE_FAST_KHZ = 400;
    // Register file geometry
    localparam int unsigned REG_AW        = 8;
    localparam int unsigned BYTE_W        = 8;
    localparam logic [7:0]  PTR_RESET     = 8'h00;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
endpackage

// [hdl/two_wire_register_port.sv]
// How it works
// R1: Select pin high enables two-wire slave
// R2: Handles 100 kHz and 400 kHz clocks
// R3: Strap high answers address 0x1D only
// R4: Strap low answers address 0x53 instead; code takes strap only while select is low; select high from reset keeps 0x1D
// R5: First byte holds address plus direction
// R6: Acknowledge address, register and data bytes
// R7: Read follows repeated start or stop-start
// R8: Drive bytes until master not-acknowledges
// R9: Pointer advances after every data byte
// R10: Unmatched address gets no acknowledge
`timescale 1ns/10ps
module two_wire_register_port
    import twi_port_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_reset_n,
    input  wire logic              i_if_select,
    input  wire logic              i_address_strap_pin,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda_oe_n,
    output logic                   o_sda_out,
    output logic [REG_AW-1:0]      o_reg_addr,
    output logic [BYTE_W-1:0]      o_reg_wdata,
    output logic                   o_reg_wr,
    output logic                   o_reg_rd,
    input  wire logic [BYTE_W-1:0] i_reg_rdata,
    output logic                   o_busy
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RECV  = 3'b001,
        ST_ACK   = 3'b010,
        ST_SEND  = 3'b011,
        ST_MACK  = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_REG  = 2'b01,
        PH_DATA = 2'b10
    } phase_t;

    typedef struct packed {
        state_t              st;
        phase_t              ph;
        logic [2:0]          bitn;
        logic [BYTE_W-1:0]   shreg;
        logic [REG_AW-1:0]   ptr;
        logic                drive_low;
        logic                ack_seen;
        logic                reading;
        logic [BYTE_W-1:0]   wdata;
        logic                wr;
        logic                rd;
        logic [1:0]          sel_sync;
        logic [1:0]          strap_sync;
        logic                strap;
    } port_t;

    port_t r_q;
    port_t r_d;

    twi_line_if line();

    twi_line_sync u_sync (  // R2
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .line      (line)
    );

    // Address match against the strapped address, write or read byte alike
    function automatic logic addr_hit(input logic [7:0] b, input logic strap);
        logic [6:0] mine;
        mine     = strap ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;  // R3 R4
        addr_hit = (b[7:1] == mine);                            // R5
    endfunction

    logic enabled;
    logic [7:0] rx_byte;
    assign enabled = r_q.sel_sync[1];
    assign rx_byte = {r_q.shreg[6:0], line.sda};

    // --------------------------------------------------------------------
    // Protocol engine
    // --------------------------------------------------------------------
    // Works purely from sampled edges; at 50 MHz a 400 kHz bus gives
    // over 60 samples per bit, ample margin for hold times.
    always_comb begin
        r_d          = r_q;
        r_d.wr       = 1'b0;
        r_d.rd       = 1'b0;
        r_d.sel_sync = {r_q.sel_sync[0], i_if_select};
        // Strap is a pin too, so it passes two stages before it is latched
        r_d.strap_sync = {r_q.strap_sync[0], i_address_strap_pin};
        r_d.strap    = r_q.sel_sync[1] ? r_q.strap : r_q.strap_sync[1];
        if (!enabled) begin
            r_d.st        = ST_IDLE;                            // R1
            r_d.drive_low = 1'b0;
        end else if (line.start_ev) begin
            // Repeated start and fresh start handled the same way
            r_d.st        = ST_RECV;                            // R7
            r_d.ph        = PH_ADDR;
            r_d.bitn      = 3'h0;
            r_d.drive_low = 1'b0;
        end else if (line.stop_ev) begin
            r_d.st        = ST_IDLE;                            // R7
            r_d.drive_low = 1'b0;
        end else begin
            case (r_q.st)
                ST_IDLE: begin
                    r_d.drive_low = 1'b0;
                end
                ST_RECV: begin
                    if (line.scl_rise) begin
                        r_d.shreg = rx_byte;
                        r_d.bitn  = r_q.bitn + 3'h1;
                        if (r_q.bitn == BIT_LAST) begin
                            r_d.st = ST_ACK;
                            if (r_q.ph == PH_ADDR) begin
                                r_d.ack_seen = addr_hit(rx_byte, r_q.strap);
                                r_d.reading  = rx_byte[0];
                            end else begin
                                r_d.ack_seen = 1'b1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // Pull low after the eighth bit's falling edge
                    if (line.scl_fall && !r_q.drive_low) begin
                        if (r_q.ack_seen) begin
                            r_d.drive_low = 1'b1;                // R6
                        end else begin
                            r_d.st = ST_IDLE;                    // R10
                        end
                    end else if (line.scl_fall && r_q.drive_low) begin
                        r_d.drive_low = 1'b0;
                        r_d.bitn      = 3'h0;
                        case (r_q.ph)
                            PH_ADDR: begin
                                if (r_q.reading) begin
                                    r_d.st        = ST_SEND;     // R8
                                    r_d.shreg     = i_reg_rdata;
                                    r_d.drive_low = ~i_reg_rdata[7];
                                    r_d.rd        = 1'b1;
                                end else begin
                                    r_d.st = ST_RECV;
                                    r_d.ph = PH_REG;
                                end
                            end
                            PH_REG: begin
                                r_d.ptr = r_q.shreg;
                                r_d.st  = ST_RECV;
                                r_d.ph  = PH_DATA;
                            end
                            default: begin
                                r_d.st = ST_RECV;
                            end
                        endcase
                    end else if (line.scl_rise && r_q.drive_low && r_q.ph == PH_DATA) begin
                        // Commit once the acknowledge is on the bus
                        if (!r_q.wr && r_q.bitn == 3'h0) begin
                            r_d.wdata = r_q.shreg;
                            r_d.wr    = 1'b1;
                            r_d.bitn  = 3'h1;
                        end
                    end
                end
                ST_SEND: begin
                    if (line.scl_fall) begin
                        r_d.bitn = r_q.bitn + 3'h1;
                        if (r_q.bitn == BIT_LAST) begin
                            r_d.drive_low = 1'b0;                // Release for master ack
                            r_d.st        = ST_MACK;
                            r_d.ptr       = r_q.ptr + 8'h01;     // R9
                        end else begin
                            r_d.shreg     = {r_q.shreg[6:0], 1'b0};
                            r_d.drive_low = ~r_q.shreg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (line.scl_rise) begin
                        r_d.ack_seen = ~line.sda;
                    end else if (line.scl_fall) begin
                        if (r_q.ack_seen) begin
                            r_d.st        = ST_SEND;
                            r_d.bitn      = 3'h0;
                            r_d.shreg     = i_reg_rdata;
                            r_d.drive_low = ~i_reg_rdata[7];
                            r_d.rd        = 1'b1;
                        end else begin
                            r_d.st = ST_IDLE;                    // R8
                        end
                    end
                end
                default: begin
                    r_d.st = ST_IDLE;
                end
            endcase
        end
        // Write pointer steps after each stored byte
        if (r_q.wr) begin
            r_d.ptr = r_q.ptr + 8'h01;                           // R9
        end
    end

    // --------------------------------------------------------------------
    // State register
    // --------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r_q <= '{st: ST_IDLE, ph: PH_ADDR, bitn: 3'h0, shreg: 8'h00,
                     ptr: PTR_RESET, drive_low: 1'b0, ack_seen: 1'b0,
                     reading: 1'b0, wdata: 8'h00, wr: 1'b0, rd: 1'b0,
                     sel_sync: 2'h0, strap_sync: 2'h3, strap: 1'b1};
        end else begin
            r_q <= r_d;
        end
    end

    // Open drain: only ever pull low, never drive high
    assign o_sda_oe_n  = ~r_q.drive_low;
    assign o_sda_out   = 1'b0;
    assign o_reg_addr  = r_q.ptr;
    assign o_reg_wdata = r_q.wdata;
    assign o_reg_wr    = r_q.wr;
    assign o_reg_rd    = r_q.rd;
    assign o_busy      = (r_q.st != ST_IDLE);
endmodule

// [verif/twi_master_model.sv]
`timescale 1ns/10ps
module twi_master_model (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe_n
);
    // Bus idles released; pull-up gives high, clock stands still between frames
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // Start or repeated start: data falls while clock high
    // Non-blocking updates: steps may land on a clock edge without a race
    task automatic start;
        o_sda_oe_n <= 1'b1;
        #40 o_scl <= 1'b1;
        #80 o_sda_oe_n <= 1'b0;
        #80 o_scl <= 1'b0;
    endtask
    task automatic stop;
        o_sda_oe_n <= 1'b0;
        #40 o_scl <= 1'b1;
        #80 o_sda_oe_n <= 1'b1;
        #200;
    endtask
    // One bit, 160 ns period; sampled late in the high phase to allow sync delay
    task automatic bit_x(input logic b, output logic r);
        o_sda_oe_n <= b;
        #40 o_scl <= 1'b1;
        #70 r = i_sda;
        #10 o_scl <= 1'b0;
        #40;
    endtask
    // Byte MSB first, then ninth bit; ack_in low acknowledges a read byte
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ack_in, ack);
    endtask
endmodule

// [verif/two_wire_register_port_asserts.sv]
`timescale 1ns/10ps
module two_wire_register_port_asserts
    import twi_port_pkg::*;
(
    input wire logic              i_mclk,
    input wire logic              i_reset_n,
    input wire logic              i_if_select,
    input wire logic              i_scl,
    input wire logic              i_sda,
    input wire logic              o_sda_oe_n,
    input wire logic              o_sda_out,
    input wire logic [REG_AW-1:0] o_reg_addr,
    input wire logic              o_reg_wr,
    input wire logic              o_reg_rd,
    input wire logic              o_busy
);
    // ------------------------------
    // Bus-side and register-side properties
    // ------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    property p_sda_out_zero; o_sda_out == 1'b0; endproperty
    a_sda_out_zero: assert property (p_sda_out_zero) else $error("Data out not zero");
    property p_sel_low_idle; !i_if_select [*4] |-> o_sda_oe_n; endproperty
    a_sel_low_idle: assert property (p_sel_low_idle) else $error("Drive while off");
    property p_wr_ptr; o_reg_wr |=> o_reg_addr == $past(o_reg_addr) + 8'h01; endproperty
    a_wr_ptr: assert property (p_wr_ptr) else $error("Pointer not advanced");
    property p_wr_pulse; o_reg_wr |=> !o_reg_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("Write pulse too long");
    property p_rd_pulse; o_reg_rd |=> !o_reg_rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("Read pulse too long");
    // Idle engine must never hold the line, or it would jam other devices
    property p_idle_rel; !o_busy |-> o_sda_oe_n; endproperty
    a_idle_rel: assert property (p_idle_rel) else $error("Drive while idle");
    property p_start_busy;
        i_if_select && $past(i_if_select, 8) && i_scl && $fell(i_sda) |-> ##[1:8] o_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("Start ignored");
    property p_ack_hold; $fell(o_sda_oe_n) |-> !o_sda_oe_n [*4]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("Low too short");
endmodule
bind two_wire_register_port two_wire_register_port_asserts u_two_wire_register_port_asserts (
    .i_mclk, .i_reset_n, .i_if_select, .i_scl, .i_sda, .o_sda_oe_n, .o_sda_out,
    .o_reg_addr, .o_reg_wr, .o_reg_rd, .o_busy);

// [verif/two_wire_register_port_tb.sv]
`timescale 1ns/10ps
module two_wire_register_port_tb
    import twi_port_pkg::*;
;
    logic       i_mclk = 1'b0, i_reset_n = 1'b0, i_if_select = 1'b1, i_address_strap_pin = 1'b1;
    logic       scl, oe_m, o_sda_oe_n, o_sda_out, o_reg_wr, o_reg_rd, o_busy;
    logic [7:0] o_reg_addr, o_reg_wdata, mem [256];
    int         n_errors = 0, num_checks = 0;
    int         n_rd = 0;
    // Open-drain wire with pull-up
    wire        sda = !(oe_m === 1'b0 || o_sda_oe_n === 1'b0);
    wire [7:0]  rdata = mem[o_reg_addr];
    always #10 i_mclk = ~i_mclk;
    // Register file stand-in
    always @(posedge i_mclk) if (o_reg_wr) mem[o_reg_addr] <= o_reg_wdata;
    // Count read strobes, one per byte fetched for sending
    always @(posedge i_mclk) if (o_reg_rd) n_rd <= n_rd + 1;
    two_wire_register_port u_two_wire_register_port (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_if_select(i_if_select), .i_address_strap_pin(i_address_strap_pin), .i_scl(scl),
        .i_sda(sda), .o_sda_oe_n(o_sda_oe_n), .o_sda_out(o_sda_out), .o_reg_addr(o_reg_addr),
        .o_reg_wdata(o_reg_wdata), .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd),
        .i_reg_rdata(rdata), .o_busy(o_busy));
    twi_master_model u_twi_master_model (.i_sda(sda), .o_scl(scl), .o_sda_oe_n(oe_m));
    // ------------------------------
    // Checking helpers
    // ------------------------------
    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: bit %b exp %b", $time, g, e);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: byte %h exp %h", $time, g, e);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic e);
        logic [7:0] r;
        logic a;
        u_twi_master_model.xfer(b, 1'b1, r, a);
        chk_bit(a, e);
    endtask
    task automatic get(input logic na, input logic [7:0] e);
        logic [7:0] r;
        logic a;
        u_twi_master_model.xfer(8'hFF, na, r, a);
        chk_byte(r, e);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    // Burst across the top of the pointer range, so the wrap is exercised
    task automatic t_write;
        u_twi_master_model.start();
        put(8'h3A, 1'b0);
        put(8'hFE, 1'b0);
        put(8'hA5, 1'b0);
        put(8'h5A, 1'b0);
        u_twi_master_model.stop();
        chk_byte(mem[8'hFE], 8'hA5);
        chk_byte(mem[8'hFF], 8'h5A);
        chk_byte(o_reg_addr, 8'h00);
        $display("t_write done");
    endtask
    task automatic t_read(input logic rs);
        int n0;
        n0 = n_rd;
        u_twi_master_model.start();
        put(8'h3A, 1'b0);
        put(8'hFE, 1'b0);
        if (!rs) u_twi_master_model.stop();
        u_twi_master_model.start();
        put(8'h3B, 1'b0);
        get(1'b0, 8'hA5);
        get(1'b1, 8'h5A);
        u_twi_master_model.stop();
        chk_bit(o_sda_oe_n, 1'b1);
        chk_byte(o_reg_addr, 8'h00);
        chk_byte(8'(n_rd - n0), 8'h02);
        $display("t_read done");
    endtask
    task automatic t_wrong;
        u_twi_master_model.start();
        put(8'hA6, 1'b1);
        u_twi_master_model.stop();
        chk_bit(o_busy, 1'b0);
        $display("t_wrong done");
    endtask
    // Strap is only taken when select goes active, so toggle select around it
    task automatic t_strap_low;
        @(posedge i_mclk);
        i_if_select <= 1'b0;
        i_address_strap_pin <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_if_select <= 1'b1;
        repeat (8) @(posedge i_mclk);
        u_twi_master_model.start();
        put(8'hA6, 1'b0);
        put(8'h01, 1'b0);
        put(8'hC3, 1'b0);
        u_twi_master_model.stop();
        chk_byte(mem[8'h01], 8'hC3);
        u_twi_master_model.start();
        put(8'h3A, 1'b1);
        u_twi_master_model.stop();
        @(posedge i_mclk);
        i_if_select <= 1'b0;
        repeat (4) @(posedge i_mclk);
        u_twi_master_model.start();
        put(8'hA6, 1'b1);
        u_twi_master_model.stop();
        $display("t_strap_low done");
    endtask
    // Watchdog: whole run needs well under 100 us
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        @(posedge i_mclk);
        #1 chk_bit(o_sda_oe_n, 1'b1);
        chk_byte(o_reg_addr, 8'h00);
        repeat (4) @(posedge i_mclk);
        t_write();
        t_read(1'b1);
        t_read(1'b0);
        t_wrong();
        t_strap_low();
        finish_test();
    end
endmodule
